// >>> design/bcc_pkg.sv
// package: register map, field layout, reset values and timing of the buck1 config block
package bcc_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 16'h4056;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 16'h4057;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 16'h40F0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'h40F1;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 16'h40F2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FREQ_LSB = 8;
    localparam int FLT_BIT = 7;
    localparam int SS_LSB = 4;
    localparam int CAP_LSB = 0;
    localparam int ERR_LSB = 14;
    localparam int SRC_LSB = 11;
    localparam int VSEL_BIT = 10;
    localparam int MODE_LSB = 8;
    localparam int IRQ_UV_BIT = 0;
    localparam int ST_SHUT_BIT = 0;
    localparam int ST_SS_BIT = 1;
    localparam int ST_HWC_BIT = 2;
    localparam int ST_ON_BIT = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] FREQ_RST = 2'h0;
    localparam logic FLT_RST = 1'b0;
    localparam logic [1:0] SS_RST = 2'h0;
    localparam logic [1:0] CAP_RST = 2'h0;
    localparam logic [1:0] ERR_RST = 2'h0;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic VSEL_RST = 1'b0;
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic MASK_RST = 1'b0;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FREQ_RSVD = 2'h0;
    localparam logic [1:0] FREQ_2M0_2U2 = 2'h1;
    localparam logic [1:0] FREQ_4M0_1U0 = 2'h2;
    localparam logic [1:0] FREQ_4M0_0U5 = 2'h3;
    localparam logic [1:0] CAP_4U7_20U = 2'h0;
    localparam logic [1:0] CAP_22U_47U = 2'h2;
    localparam logic [1:0] ERR_IGNORE = 2'h0;
    localparam logic [1:0] ERR_SHUT_CONV = 2'h1;
    localparam logic [1:0] ERR_SHUT_SYS = 2'h2;
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_HWC1 = 2'h1;
    localparam logic [1:0] SRC_HWC2 = 2'h2;
    localparam logic [1:0] SRC_EITHER = 2'h3;
    localparam logic [1:0] MODE_FCCM = 2'h0;
    localparam logic [1:0] MODE_OFF = 2'h1;
    localparam logic [1:0] MODE_LDO = 2'h2;
    localparam logic [1:0] MODE_HYST = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SS_STEPS = 8;
    localparam int SS_BASE_US = 32;
    localparam int SS_BASE_CYC = SS_BASE_US * CLK_MHZ;
    localparam int SS_CNT_W = 17;
endpackage

// >>> design/bcc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module bcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // ------------------------------------------------------------
    // first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // bcc_sync
`default_nettype wire

// >>> design/bcc_softstart.sv
// soft-start sequencer: eight current-limit steps of selectable length
`timescale 1ns/10ps
`default_nettype none
module bcc_softstart
    import bcc_pkg::*;
#(
    parameter int unsigned BASE_CYC = bcc_pkg::SS_BASE_CYC,
    parameter int CNT_W = bcc_pkg::SS_CNT_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [1:0] step_sel,
    output logic [2:0] step_r,
    output logic active_r
);
    typedef enum logic [1:0] {SS_IDLE, SS_RUN, SS_DONE} bcc_ss_state_t;

    bcc_ss_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] len;
    logic [2:0] step_nxt;
    logic active_nxt;

    // ------------------------------------------------------------
    // step sequencing
    // ------------------------------------------------------------
    always_comb begin
        len = CNT_W'(BASE_CYC) << step_sel; // 32/64/128/256 us per step
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        step_nxt = step_r;
        if (!run) begin
            // dropping run aborts the ramp at any point
            state_nxt = SS_IDLE;
            cnt_nxt = '0;
            step_nxt = 3'h0;
        end else begin
            unique case (state_r)
                SS_IDLE: begin
                    state_nxt = SS_RUN;
                    cnt_nxt = '0;
                    step_nxt = 3'h0;
                end
                SS_RUN: begin
                    if (cnt_r >= len - CNT_W'(1)) begin
                        cnt_nxt = '0;
                        if (step_r == 3'(SS_STEPS - 1)) begin
                            state_nxt = SS_DONE;
                        end else begin
                            step_nxt = step_r + 3'h1;
                        end
                    end else begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
                SS_DONE: begin
                    state_nxt = SS_DONE;
                end
            endcase
        end
        active_nxt = (state_nxt == SS_RUN);
    end

    // registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= SS_IDLE;
            cnt_r <= '0;
            step_r <= 3'h0;
            active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
            active_r <= active_nxt;
        end
    end
endmodule // bcc_softstart
`default_nettype wire

// >>> design/bcc_ctrl.sv
// buck1 configuration and control: registers, undervoltage response, hardware-control override
`timescale 1ns/10ps
`default_nettype none
module bcc_ctrl #(
    parameter int unsigned SS_BASE_CYC = bcc_pkg::SS_BASE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [bcc_pkg::ADDR_W-1:0] addr,
    input wire logic [bcc_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [bcc_pkg::DATA_W-1:0] rd_data,
    input wire logic cfg_load,
    input wire logic [1:0] cfg_switch_freq,
    input wire logic [1:0] cfg_output_cap_range,
    input wire logic conv_enable_req,
    input wire logic [1:0] normal_op_mode,
    input wire logic hw_ctrl_1,
    input wire logic hw_ctrl_2,
    input wire logic uv_error,
    output logic [1:0] buck1_switch_freq,
    output logic [1:0] buck1_output_cap_range,
    output logic conv_on,
    output logic output_discharge,
    output logic [2:0] softstart_step,
    output logic softstart_active,
    output logic use_sleep_voltage,
    output logic [1:0] eff_op_mode,
    output logic hw_ctrl_active,
    output logic sys_reset_req,
    output logic irq
);
    import bcc_pkg::*;

    logic [1:0] freq_r, freq_nxt, cap_r, cap_nxt, ss_r, ss_nxt;
    logic float_r, float_nxt;
    logic [1:0] err_r, err_nxt, src_r, src_nxt, mode_r, mode_nxt;
    logic vsel_r, vsel_nxt;
    logic sts_r, sts_nxt, mask_r, mask_nxt, irq_nxt;
    logic shut_r, shut_nxt, sysrst_nxt, uv_d_r;
    logic on_nxt, dis_nxt, sleep_nxt, hwa_nxt;
    logic [1:0] opm_nxt;
    logic [DATA_W-1:0] rd_nxt;
    logic [2:0] pins_s;
    logic uv_rise, wr1, wr2;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    bcc_sync #(.WIDTH(3)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({uv_error, hw_ctrl_2, hw_ctrl_1}),
        .sync_out(pins_s)
    );

    assign uv_rise = pins_s[2] && !uv_d_r; // one event per error, not per cycle
    assign wr1 = wr_en && (addr == ADDR_CTRL1);
    assign wr2 = wr_en && (addr == ADDR_CTRL2);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_comb begin
        freq_nxt = freq_r;
        cap_nxt = cap_r;
        float_nxt = float_r;
        ss_nxt = ss_r;
        err_nxt = err_r;
        src_nxt = src_r;
        vsel_nxt = vsel_r;
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        // bus writes cannot touch these two; only a memory load does
        if (cfg_load) begin
            freq_nxt = cfg_switch_freq;
            cap_nxt = cfg_output_cap_range;
        end
        if (wr1) begin
            float_nxt = wr_data[FLT_BIT];
            ss_nxt = wr_data[SS_LSB +: 2];
        end
        if (wr2) begin
            err_nxt = wr_data[ERR_LSB +: 2];
            src_nxt = wr_data[SRC_LSB +: 2];
            vsel_nxt = wr_data[VSEL_BIT];
            mode_nxt = wr_data[MODE_LSB +: 2];
        end
        if (wr_en && addr == ADDR_IRQ_MASK) begin
            mask_nxt = wr_data[IRQ_UV_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            freq_r <= FREQ_RST;
            cap_r <= CAP_RST;
            float_r <= FLT_RST;
            ss_r <= SS_RST;
            err_r <= ERR_RST;
            src_r <= SRC_RST;
            vsel_r <= VSEL_RST;
            mode_r <= MODE_RST;
            mask_r <= MASK_RST;
        end else begin
            freq_r <= freq_nxt;
            cap_r <= cap_nxt;
            float_r <= float_nxt;
            ss_r <= ss_nxt;
            err_r <= err_nxt;
            src_r <= src_nxt;
            vsel_r <= vsel_nxt;
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // undervoltage response, interrupt and converter control
    // ------------------------------------------------------------
    always_comb begin
        // interrupt regardless of action; set beats read-clear
        sts_nxt = sts_r;
        if (rd_en && addr == ADDR_IRQ_STS) begin
            sts_nxt = 1'b0;
        end
        if (uv_rise) begin
            sts_nxt = 1'b1;
        end
        irq_nxt = sts_nxt && !mask_nxt; // mask bit set blocks the line
        // shutdown latch holds until software withdraws the enable request
        shut_nxt = shut_r;
        if (!conv_enable_req) begin
            shut_nxt = 1'b0;
        end
        if (uv_rise && err_r == ERR_SHUT_CONV) begin
            shut_nxt = 1'b1;
        end
        sysrst_nxt = uv_rise && (err_r == ERR_SHUT_SYS);
        // reserved action code 11 is treated as ignore
        unique case (src_r)
            SRC_NONE: hwa_nxt = 1'b0;
            SRC_HWC1: hwa_nxt = pins_s[0];
            SRC_HWC2: hwa_nxt = pins_s[1];
            SRC_EITHER: hwa_nxt = pins_s[0] || pins_s[1];
        endcase
        if (hwa_nxt) begin
            sleep_nxt = vsel_r;
            opm_nxt = mode_r;
        end else begin
            sleep_nxt = 1'b0;
            opm_nxt = normal_op_mode;
        end
        on_nxt = conv_enable_req && !shut_nxt && (opm_nxt != MODE_OFF);
        dis_nxt = !on_nxt && !float_r;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sts_r <= 1'b0;
            irq <= 1'b0;
            shut_r <= 1'b0;
            sys_reset_req <= 1'b0;
            uv_d_r <= 1'b0;
            hw_ctrl_active <= 1'b0;
            use_sleep_voltage <= 1'b0;
            eff_op_mode <= MODE_RST;
            conv_on <= 1'b0;
            output_discharge <= 1'b1;
        end else begin
            sts_r <= sts_nxt;
            irq <= irq_nxt;
            shut_r <= shut_nxt;
            sys_reset_req <= sysrst_nxt;
            uv_d_r <= pins_s[2];
            hw_ctrl_active <= hwa_nxt;
            use_sleep_voltage <= sleep_nxt;
            eff_op_mode <= opm_nxt;
            conv_on <= on_nxt;
            output_discharge <= dis_nxt;
        end
    end

    // ------------------------------------------------------------
    // soft-start sequencer, restarted by each turn-on
    // ------------------------------------------------------------
    bcc_softstart #(.BASE_CYC(SS_BASE_CYC), .CNT_W(SS_CNT_W)) u_ss (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(conv_on),
        .step_sel(ss_r),
        .step_r(softstart_step),
        .active_r(softstart_active)
    );

    // ------------------------------------------------------------
    // read path and field outputs
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = '0; // unmapped addresses and idle cycles read zero
        if (rd_en) begin
            unique case (addr)
                ADDR_CTRL1: begin
                    rd_nxt[FREQ_LSB +: 2] = freq_r;
                    rd_nxt[FLT_BIT] = float_r;
                    rd_nxt[SS_LSB +: 2] = ss_r;
                    rd_nxt[CAP_LSB +: 2] = cap_r;
                end
                ADDR_CTRL2: begin
                    rd_nxt[ERR_LSB +: 2] = err_r;
                    rd_nxt[SRC_LSB +: 2] = src_r;
                    rd_nxt[VSEL_BIT] = vsel_r;
                    rd_nxt[MODE_LSB +: 2] = mode_r;
                end
                ADDR_IRQ_STS: rd_nxt[IRQ_UV_BIT] = sts_r;
                ADDR_IRQ_MASK: rd_nxt[IRQ_UV_BIT] = mask_r;
                ADDR_STATE: begin
                    rd_nxt[ST_SHUT_BIT] = shut_r;
                    rd_nxt[ST_SS_BIT] = softstart_active;
                    rd_nxt[ST_HWC_BIT] = hw_ctrl_active;
                    rd_nxt[ST_ON_BIT] = conv_on;
                end
                default: rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data <= '0;
            buck1_switch_freq <= FREQ_RST;
            buck1_output_cap_range <= CAP_RST;
        end else begin
            rd_data <= rd_nxt;
            buck1_switch_freq <= freq_nxt;
            buck1_output_cap_range <= cap_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_freq_read_only: assert property (
        (wr1 && !cfg_load) |=> (freq_r == $past(freq_r)) && (cap_r == $past(cap_r)))
        else $error("frequency or capacitor field changed by a bus write");
    chk_freq_cfg_load: assert property (
        cfg_load |=> ##1 buck1_switch_freq == $past(cfg_switch_freq, 2))
        else $error("frequency output did not follow configuration load");
    chk_cap_cfg_load: assert property (
        cfg_load |=> cap_r == $past(cfg_output_cap_range))
        else $error("capacitor field not loaded from configuration memory");
    chk_float_discharge: assert property (
        (!conv_on && $past(float_r) && !$past(wr1)) |-> !output_discharge)
        else $error("floating output was discharged");
    chk_uv_irq_always: assert property (
        uv_rise |=> sts_r && (irq || mask_r))
        else $error("undervoltage error raised no interrupt");
    chk_uv_shut_conv: assert property (
        (uv_rise && err_r == ERR_SHUT_CONV) |=> shut_r && !conv_on && !sys_reset_req)
        else $error("converter not shut down on undervoltage");
    chk_uv_sys_reset: assert property (
        (uv_rise && err_r == ERR_SHUT_SYS) |=> sys_reset_req ##1 !sys_reset_req)
        else $error("system reset request not a single pulse");
    chk_uv_ignore: assert property (
        (uv_rise && err_r == ERR_IGNORE && !shut_r) |=> !shut_r && !sys_reset_req)
        else $error("ignored undervoltage changed converter state");
    chk_hwc_source_off: assert property (
        (src_r == SRC_NONE) |=> !hw_ctrl_active && eff_op_mode == $past(normal_op_mode))
        else $error("hardware control active with source disabled");
    chk_hwc_volt_mode: assert property (
        hw_ctrl_active |-> use_sleep_voltage == $past(vsel_r) && eff_op_mode == $past(mode_r))
        else $error("hardware control voltage or mode not applied");
    chk_normal_sel: assert property (
        !hw_ctrl_active |-> !use_sleep_voltage)
        else $error("sleep voltage used without hardware control");
    chk_hwc_mode_off: assert property (
        (hw_ctrl_active && eff_op_mode == MODE_OFF) |-> !conv_on)
        else $error("converter on while hardware mode is disabled");
    chk_ss_step_order: assert property (
        (softstart_active && $past(softstart_active)) |->
            softstart_step == $past(softstart_step) || softstart_step == $past(softstart_step) + 3'h1)
        else $error("soft-start step skipped");

    cov_uv_shutdown: cover property (uv_rise && err_r == ERR_SHUT_CONV ##1 shut_r);
    cov_hwc_sleep: cover property (hw_ctrl_active && use_sleep_voltage);
    cov_ss_done: cover property ($fell(softstart_active) && conv_on);
    cov_cfg_load: cover property (cfg_load && cfg_switch_freq == FREQ_4M0_0U5);
endmodule // bcc_ctrl
`default_nettype wire

// >>> tb/test_buck_converter_config_ctrl.sv
// self-checking testbench for the buck1 configuration and control block
`timescale 1ns/10ps
`default_nettype none
module test_buck_converter_config_ctrl;
    import bcc_pkg::*;
    // short soft-start steps keep the run brief; expectations scale from this
    localparam int BASE = 4;
    logic sys_clk, reset, wr_en, rd_en, cfg_load, conv_enable_req, hw_ctrl_1, hw_ctrl_2, uv_error;
    logic [15:0] addr, wr_data, rd_data;
    logic [1:0] cfg_switch_freq, cfg_output_cap_range, normal_op_mode, freq_o, cap_o, eff_op_mode;
    logic conv_on, output_discharge, softstart_active, use_sleep_voltage, hw_ctrl_active, sys_reset_req, irq;
    logic [2:0] softstart_step;
    int num_errors = 0;
    int compares = 0;
    int pulses = 0;

    bcc_ctrl #(.SS_BASE_CYC(BASE)) DUT (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cfg_load(cfg_load), .cfg_switch_freq(cfg_switch_freq),
        .cfg_output_cap_range(cfg_output_cap_range), .conv_enable_req(conv_enable_req),
        .normal_op_mode(normal_op_mode), .hw_ctrl_1(hw_ctrl_1), .hw_ctrl_2(hw_ctrl_2), .uv_error(uv_error),
        .buck1_switch_freq(freq_o), .buck1_output_cap_range(cap_o), .conv_on(conv_on),
        .output_discharge(output_discharge), .softstart_step(softstart_step), .softstart_active(softstart_active),
        .use_sleep_voltage(use_sleep_voltage), .eff_op_mode(eff_op_mode), .hw_ctrl_active(hw_ctrl_active),
        .sys_reset_req(sys_reset_req), .irq(irq));

    // ------------------------------------------------------------
    // clock, pulse monitor, shared tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // system reset request is a one-cycle pulse, so count it every edge
    always @(posedge sys_clk) begin
        if (sys_reset_req === 1'b1) pulses <= pulses + 1;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdc(input string name, input logic [15:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(name, exp, rd_data);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc("ctrl1", ADDR_CTRL1, 16'h0000);
        rdc("ctrl2", ADDR_CTRL2, 16'h0300);
        rdc("unmapped", 16'h4059, 16'h0000);
        chk("discharge", 16'h0001, output_discharge);
        $display("test reset done, mismatches %0d", num_errors);
    endtask

    // bus writes must not touch the load-only fields; a load does
    task automatic t_cfg();
        wr(ADDR_CTRL1, 16'hFFFF);
        rdc("ctrl1 bus", ADDR_CTRL1, 16'h00B0);
        wr(ADDR_CTRL1, 16'h0000);
        for (int f = 1; f < 4; f++) begin
            @(posedge sys_clk);
            cfg_switch_freq <= 2'(f);
            cfg_output_cap_range <= CAP_22U_47U;
            cfg_load <= 1'b1;
            @(posedge sys_clk);
            cfg_load <= 1'b0;
            wait_cyc(2);
            chk("freq port", 16'(f), freq_o);
            chk("cap port", 16'(CAP_22U_47U), cap_o);
            rdc("ctrl1 load", ADDR_CTRL1, (16'(f) << 8) | 16'h0002);
        end
        $display("test cfg done, mismatches %0d", num_errors);
    endtask

    task automatic t_float();
        wr(ADDR_CTRL1, 16'h0080);
        wait_cyc(2);
        chk("float", 16'h0000, output_discharge);
        wr(ADDR_CTRL1, 16'h0000);
        wait_cyc(2);
        chk("discharge", 16'h0001, output_discharge);
        $display("test float done, mismatches %0d", num_errors);
    endtask

    // every code: eight steps of BASE<<code cycles
    task automatic t_softstart();
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CTRL1, 16'(c) << 4);
            conv_enable_req <= 1'b1;
            n = 0;
            while (softstart_active !== 1'b1 && n < 50) begin
                wait_cyc(1);
                n++;
            end
            n = 0;
            while (softstart_active === 1'b1 && n < 2000) begin
                wait_cyc(1);
                n++;
            end
            chk("ss cycles", 16'(SS_STEPS * (BASE << c)), 16'(n));
            chk("ss last step", 16'(SS_STEPS - 1), softstart_step);
            conv_enable_req <= 1'b0;
            wait_cyc(4);
        end
        $display("test softstart done, mismatches %0d", num_errors);
    endtask

    task automatic uv_pulse();
        @(posedge sys_clk);
        uv_error <= 1'b1;
        repeat (6) @(posedge sys_clk);
        uv_error <= 1'b0;
        #1;
    endtask

    task automatic t_uv();
        int p0;
        conv_enable_req <= 1'b1;
        wait_cyc(8);
        for (int a = 0; a < 3; a++) begin
            wr(ADDR_CTRL2, (16'(a) << 14) | 16'h0300);
            p0 = pulses;
            uv_pulse();
            chk("irq", 16'h0001, irq);
            chk("conv on", 16'(a != 1), conv_on);
            chk("sys reset", 16'(a == 2), 16'(pulses - p0));
            rdc("state", ADDR_STATE, (a == 1) ? 16'h0001 : 16'h000A);
            rdc("status", ADDR_IRQ_STS, 16'h0001);
            chk("irq clear", 16'h0000, irq);
            conv_enable_req <= 1'b0;
            wait_cyc(3);
            conv_enable_req <= 1'b1;
            wait_cyc(3);
        end
        // masked event still sets the sticky status bit
        wr(ADDR_IRQ_MASK, 16'h0001);
        uv_pulse();
        chk("irq masked", 16'h0000, irq);
        wr(ADDR_IRQ_MASK, 16'h0000);
        wait_cyc(1);
        chk("irq unmasked", 16'h0001, irq);
        rdc("status", ADDR_IRQ_STS, 16'h0001);
        $display("test uv done, mismatches %0d", num_errors);
    endtask

    // every source code against every pin pair, vsel set, mode LDO
    task automatic t_hwc();
        logic act;
        wr(ADDR_CTRL2, 16'h0300);
        normal_op_mode <= MODE_HYST; // distinct from the hardware-control mode
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 4; p++) begin
                wr(ADDR_CTRL2, (16'(s) << 11) | 16'h0600);
                hw_ctrl_1 <= p[0];
                hw_ctrl_2 <= p[1];
                wait_cyc(5);
                act = (s[0] & p[0]) | (s[1] & p[1]);
                chk("hwc active", 16'(act), hw_ctrl_active);
                chk("sleep sel", 16'(act), use_sleep_voltage);
                chk("mode", act ? 16'(MODE_LDO) : 16'(MODE_HYST), eff_op_mode);
            end
        end
        // input 1 still high: source 1 with mode disabled must stop the converter
        wr(ADDR_CTRL2, 16'h0900);
        wait_cyc(3);
        chk("hwc off mode", 16'(MODE_OFF), eff_op_mode);
        chk("hwc off conv", 16'h0000, conv_on);
        hw_ctrl_1 <= 1'b0;
        hw_ctrl_2 <= 1'b0;
        $display("test hwc done, mismatches %0d", num_errors);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {reset, wr_en, rd_en, cfg_load, conv_enable_req, hw_ctrl_1, hw_ctrl_2, uv_error} = 8'h80;
        addr = 16'h0000;
        wr_data = 16'h0000;
        cfg_switch_freq = 2'h0;
        cfg_output_cap_range = 2'h0;
        normal_op_mode = MODE_FCCM;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_cfg();
        t_float();
        t_softstart();
        t_uv();
        t_hwc();
        results();
    end

    // all scenarios need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("ERROR watchdog expected done seen timeout");
        results();
    end
endmodule // test_buck_converter_config_ctrl
`default_nettype wire
